// >>> logic/fbp_protect.sv
// Purpose: Flash control interlocks governed by the block protect byte.
// Assumes: CPU writes control bits directly; the flash array does the cell work.
// Notes: Protect byte is mirrored from the array and updated on array writes only.
`default_nettype none
module fbp_protect
  import fbp_pkg::*;
(
  input wire logic core_clk_i, // 50 MHz bus clock
  input wire logic reset_i, // Async reset, active high
  input wire logic test_voltage_i, // Test voltage detect on IRQ pin (async)
  input wire logic array_load_i, // Protect byte loaded from array at boot
  input wire logic [7:0] array_byte_i, // Boot value of protect byte
  input wire logic latch_i, // CPU write to a flash address (latches target)
  input wire logic [fbp_pkg::ADDR_W-1:0] latch_addr_i, // Address of that write
  input wire logic [7:0] latch_data_i, // Data of that write
  input wire logic ctrl_wr_i, // CPU write to control bits
  input wire logic program_select_i, // Requested program select
  input wire logic erase_i, // Requested erase select
  input wire logic mass_i, // Requested mass erase select
  input wire logic high_voltage_enable_i, // Requested high voltage enable
  output logic program_select_o, // Program select state
  output logic erase_o, // Erase select state
  output logic mass_o, // Mass erase state
  output logic high_voltage_enable_o, // High voltage enabled
  output logic [7:0] flash_protect_start_o, // Protect byte read value
  output logic [fbp_pkg::ADDR_W-1:0] start_addr_o, // Current protect start
  output logic refused_o // Pulse: a high voltage request was refused
);
  import fbp_pkg::*;

  typedef struct packed {
    logic tv_meta;
    logic tv_sync;
    logic program_select;
    logic ers;
    logic mass;
    logic high_voltage_enable;
    logic refused;
    logic [7:0] bpr;
    logic [ADDR_W-1:0] target;
    logic [7:0] data;
  } fbp_state_type;

  fbp_state_type cur, next_cur;
  logic tgt_prot;
  logic [ADDR_W-1:0] start_addr;
  logic hv_allow;
  logic bpr_hit;

  fbp_range_check u_check (
    .protect_start_bits_i(cur.bpr),
    .target_i(cur.target),
    .start_addr_o(start_addr),
    .protected_o(tgt_prot)
  );

  // ------------------------------------------------------------
  // Interlock decode
  // ------------------------------------------------------------
  always_comb begin
    bpr_hit = (cur.target & ERASE_PAGE_MASK) == (PROTECT_BYTE_ADDR & ERASE_PAGE_MASK);
    if (cur.mass) begin
      hv_allow = cur.ers && (cur.bpr == NO_PROTECT) && cur.tv_sync;
    end else begin
      hv_allow = (cur.program_select ^ cur.ers) && !tgt_prot
        && (!bpr_hit || cur.tv_sync);
    end
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.tv_meta = test_voltage_i;
    next_cur.tv_sync = cur.tv_meta;
    next_cur.refused = 1'b0;
    if (array_load_i) begin
      next_cur.bpr = array_byte_i;
    end
    if (latch_i && !cur.high_voltage_enable) begin
      next_cur.target = latch_addr_i;
      next_cur.data = latch_data_i;
    end
    if (ctrl_wr_i) begin
      // Program and erase may never both be set
      next_cur.program_select = program_select_i && !erase_i;
      next_cur.ers = erase_i && !program_select_i;
      next_cur.mass = mass_i;
      // An array cycle ends when its select bit drops while high voltage is on;
      // the select is cleared before high voltage, so the mirror follows there
      if (cur.high_voltage_enable && cur.program_select && !next_cur.program_select && cur.target == PROTECT_BYTE_ADDR) begin
        next_cur.bpr = cur.bpr & cur.data;
      end else if (cur.high_voltage_enable && cur.ers && !next_cur.ers && (bpr_hit || cur.mass)) begin
        next_cur.bpr = NO_PROTECT;
      end
      if (high_voltage_enable_i && !cur.high_voltage_enable) begin
        next_cur.high_voltage_enable = hv_allow;
        next_cur.refused = !hv_allow;
      end else if (!high_voltage_enable_i) begin
        next_cur.high_voltage_enable = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cur <= '0;
      cur.bpr <= PROTECT_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  assign program_select_o = cur.program_select;
  assign erase_o = cur.ers;
  assign mass_o = cur.mass;
  assign high_voltage_enable_o = cur.high_voltage_enable;
  assign flash_protect_start_o = cur.bpr;
  assign start_addr_o = start_addr;
  assign refused_o = cur.refused;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_start_form;
    @(posedge core_clk_i) disable iff (reset_i)
      start_addr_o[15:14] == 2'b11 && start_addr_o[5:0] == 6'h00
      && start_addr_o[13:6] == flash_protect_start_o;
  endproperty
  a_start_form: assert property (p_start_form) else $error("start address malformed");

  property p_no_hv_protected;
    @(posedge core_clk_i) disable iff (reset_i)
      $rose(high_voltage_enable_o) && !mass_o |-> !$past(tgt_prot);
  endproperty
  a_no_hv_protected: assert property (p_no_hv_protected) else $error("hv on protected");

  property p_mass_inhibit;
    @(posedge core_clk_i) disable iff (reset_i)
      $rose(high_voltage_enable_o) && mass_o |-> $past(flash_protect_start_o) == 8'hFF;
  endproperty
  a_mass_inhibit: assert property (p_mass_inhibit) else $error("mass erase while protected");

  property p_all_protect;
    @(posedge core_clk_i) disable iff (reset_i)
      flash_protect_start_o <= 8'hB8 && flash_protect_start_o != 8'hFF |-> tgt_prot;
  endproperty
  a_all_protect: assert property (p_all_protect) else $error("low value not fully protected");

  property p_none_protect;
    @(posedge core_clk_i) disable iff (reset_i)
      flash_protect_start_o == 8'hFF |-> !tgt_prot;
  endproperty
  a_none_protect: assert property (p_none_protect) else $error("FF still protects");

  property p_range;
    @(posedge core_clk_i) disable iff (reset_i)
      flash_protect_start_o > 8'hB8 && flash_protect_start_o != 8'hFF
      |-> tgt_prot == (cur.target >= start_addr_o);
  endproperty
  a_range: assert property (p_range) else $error("range compare wrong");

  property p_fe;
    @(posedge core_clk_i) disable iff (reset_i)
      flash_protect_start_o == 8'hFE |-> start_addr_o == 16'hFF80;
  endproperty
  a_fe: assert property (p_fe) else $error("FE start wrong");

  property p_bpr_stable;
    @(posedge core_clk_i) disable iff (reset_i)
      !high_voltage_enable_o && !array_load_i |=> $stable(flash_protect_start_o);
  endproperty
  a_bpr_stable: assert property (p_bpr_stable) else $error("protect byte changed");

  property p_bpr_tv;
    @(posedge core_clk_i) disable iff (reset_i)
      $rose(high_voltage_enable_o) && !mass_o && bpr_hit |-> $past(cur.tv_sync);
  endproperty
  a_bpr_tv: assert property (p_bpr_tv) else $error("protect page hv without test voltage");

  property p_refuse;
    @(posedge core_clk_i) disable iff (reset_i)
      ctrl_wr_i && high_voltage_enable_i && !high_voltage_enable_o && !hv_allow
      |=> refused_o && !high_voltage_enable_o;
  endproperty
  a_refuse: assert property (p_refuse) else $error("refusal missing");

  c_hv_on: cover property (@(posedge core_clk_i) $rose(high_voltage_enable_o));
  c_refused: cover property (@(posedge core_clk_i) refused_o);
  c_mass: cover property (@(posedge core_clk_i) $rose(high_voltage_enable_o) && mass_o);
  c_mirror_prog: cover property (@(posedge core_clk_i)
    !$past(array_load_i) && $changed(flash_protect_start_o));

  property p_hv_one_select;
    @(posedge core_clk_i) disable iff (reset_i)
      $rose(high_voltage_enable_o) |-> $past(program_select_o) != $past(erase_o);
  endproperty
  a_hv_one_select: assert property (p_hv_one_select) else $error("hv without one select");

  property p_refused_no_hv;
    @(posedge core_clk_i) disable iff (reset_i)
      refused_o |-> !high_voltage_enable_o;
  endproperty
  a_refused_no_hv: assert property (p_refused_no_hv) else $error("refusal with hv on");

  // Program can only clear bits and erase sets them all, so no other change is legal
  property p_mirror_change;
    @(posedge core_clk_i) disable iff (reset_i)
      !$past(array_load_i) && $changed(flash_protect_start_o)
      |-> flash_protect_start_o == 8'hFF
      || (flash_protect_start_o | $past(flash_protect_start_o)) == $past(flash_protect_start_o);
  endproperty
  a_mirror_change: assert property (p_mirror_change) else $error("protect byte changed oddly");

  // Target frozen under high voltage, so the checked address is the one written
  property p_target_frozen;
    @(posedge core_clk_i) disable iff (reset_i)
      high_voltage_enable_o |=> $stable(cur.target);
  endproperty
  a_target_frozen: assert property (p_target_frozen) else $error("target moved under hv");
endmodule : fbp_protect
`default_nettype wire

// >>> pkg/fbp_pkg.sv
// Purpose: Constants for the flash block protect logic.
// Assumes: 16-bit flash address space whose protected range ends at the top location.
// Notes: The protect byte lives in the flash array at the address given below.
// Function
// - The protect byte sits inside the flash array and changes only by a flash program or erase.
// - The start address is 2'b11, the eight protect bits, then six zero bits.
// - Every address from the start address up to the top location is protected.
// - A protect value up to B8 hex protects the whole flash array.
// - A protect value of FF hex protects nothing.
// - A protect value of FE hex starts protection at FF80 hex, covering the top two erase pages.
// - High-voltage enable is refused when the target lies in the protected range.
// - Mass erase is inhibited whenever the protect value is not FF hex.
// - The protect byte may be changed only while the test voltage is seen on the IRQ pin.
`default_nettype none
package fbp_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] PROTECT_BYTE_ADDR = 16'hFFBE;
  localparam logic [15:0] FLASH_TOP = 16'hFFFF;
  localparam logic [7:0] NO_PROTECT = 8'hFF;
  localparam logic [7:0] ALL_PROTECT_MAX = 8'hB8;
  localparam logic [7:0] PROTECT_RESET = 8'hFF;
  localparam int START_LO = 6;
  localparam int START_HI = 13;
  localparam logic [1:0] START_TOP_BITS = 2'b11;
  localparam logic [5:0] START_LOW_BITS = 6'h00;
  localparam logic [15:0] ERASE_PAGE_MASK = 16'hFFC0;
endpackage : fbp_pkg
`default_nettype wire

// >>> logic/fbp_range_check.sv
// Purpose: Protect start address expansion and range compare.
// Assumes: Pure combinational helper.
// Notes: Low protect values cover the whole array, FF covers nothing.
`default_nettype none
module fbp_range_check
  import fbp_pkg::*;
(
  input wire logic [7:0] protect_start_bits_i, // Stored protect byte
  input wire logic [fbp_pkg::ADDR_W-1:0] target_i, // Address to check
  output logic [fbp_pkg::ADDR_W-1:0] start_addr_o, // Expanded start address
  output logic protected_o // Target lies in the protected range
);
  import fbp_pkg::*;
  always_comb begin
    start_addr_o = {START_TOP_BITS, protect_start_bits_i, START_LOW_BITS};
    if (protect_start_bits_i == NO_PROTECT) begin
      protected_o = 1'b0;
    end else if (protect_start_bits_i <= ALL_PROTECT_MAX) begin
      protected_o = 1'b1;
    end else begin
      protected_o = (target_i >= start_addr_o) && (target_i <= FLASH_TOP);
    end
  end
endmodule : fbp_range_check
`default_nettype wire

// >>> verif/flash_block_protect_tb.sv
// Purpose: Self-checking bench for the flash block protect interlocks.
// Assumes: Outputs update one cycle after the taking edge; test voltage syncs in two edges.
// Notes: Driver queues verdicts and protect byte values; a monitor pops them on each event.
`default_nettype none
module flash_block_protect_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fbp_pkg::*;
  // ----------------------------------------
  // Signals and expectation queues
  // ----------------------------------------
  logic core_clk_i = 1'b0, reset_i = 1'b1, tv = 1'b0, ld = 1'b0, lt = 1'b0, cw = 1'b0;
  logic p = 1'b0, e = 1'b0, m = 1'b0, h = 1'b0, pso, eo, mo, hvo, ref_o, hv_q = 1'b0;
  logic [7:0] ab = 8'hFF, ld_d = 8'h00, pb, pb_q = 8'hFF, cb = 8'hFF;
  logic [15:0] la = 16'h0000, sa, a;
  logic [23:0] pq[$];
  logic vq[$];
  logic [2:0] cq[$];
  logic cw_q = 1'b0;
  logic [2:0] modes [4] = '{3'b100, 3'b010, 3'b011, 3'b110};
  logic [7:0] tbl [5] = '{8'h00, 8'hB8, 8'hB9, 8'hFE, 8'hFF};
  int err_count = 0, n_tests = 0, cyc = 0;
  fbp_protect u_dut (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .test_voltage_i(tv), .array_load_i(ld),
    .array_byte_i(ab), .latch_i(lt), .latch_addr_i(la), .latch_data_i(ld_d), .ctrl_wr_i(cw),
    .program_select_i(p), .erase_i(e), .mass_i(m), .high_voltage_enable_i(h),
    .program_select_o(pso), .erase_o(eo), .mass_o(mo), .high_voltage_enable_o(hvo),
    .flash_protect_start_o(pb), .start_addr_o(sa), .refused_o(ref_o));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [23:0] ex, input logic [23:0] got);
    n_tests++;
    if (ex !== got) begin
      err_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, ex, got);
    end
  endtask : chk
  task automatic chk_ref(input logic ex, input logic got);
    chk({23'h0, ex}, {23'h0, got});
  endtask : chk_ref
  task automatic summarize();
    err_count += pq.size() + vq.size() + cq.size();
    $display("Counts: %0d checks, %0d errors", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  // Verdict from the rules alone: 1 means the high voltage set must be refused
  function automatic logic xref(input logic [2:0] md, input logic [15:0] t);
    if (md[2] == md[1]) return 1'b1;
    if (md[0]) return cb !== NO_PROTECT || !tv;
    if (t[15:6] == PROTECT_BYTE_ADDR[15:6] && !tv) return 1'b1;
    return cb !== NO_PROTECT && (cb <= ALL_PROTECT_MAX || t >= {2'b11, cb, 6'h00});
  endfunction : xref
  task automatic ctl(input logic [3:0] v);
    // Program and erase requested together must both read back clear
    cq.push_back({v[3] && !v[2], v[2] && !v[3], v[1]});
    @(posedge core_clk_i);
    cw <= 1'b1;
    {p, e, m, h} <= v;
    @(posedge core_clk_i);
    cw <= 1'b0;
  endtask : ctl
  task automatic settv(input logic v);
    @(posedge core_clk_i);
    tv <= v;
    repeat (3) @(posedge core_clk_i);
  endtask : settv
  task automatic load(input logic [7:0] b);
    // A repeated value would leave no visible change for the monitor
    if (b === cb) b = b ^ 8'h01;
    pq.push_back({b, 2'b11, b, 6'h00});
    cb = b;
    @(posedge core_clk_i);
    ld <= 1'b1;
    ab <= b;
    @(posedge core_clk_i);
    ld <= 1'b0;
  endtask : load
  task automatic hv(input logic [2:0] md, input logic [15:0] t, input logic [7:0] d);
    logic r;
    r = xref(md, t);
    vq.push_back(r);
    ctl({md, 1'b0});
    chk({16'h0, cb}, {16'h0, pb});
    @(posedge core_clk_i);
    lt <= 1'b1;
    la <= t;
    ld_d <= d;
    @(posedge core_clk_i);
    lt <= 1'b0;
    ctl({md, 1'b1});
    // After a refusal a further request with high voltage would be a second attempt
    if (!r) ctl(4'h1);
    if (!r && md[2] && t == PROTECT_BYTE_ADDR && (cb & d) !== cb) begin
      cb = cb & d;
      pq.push_back({cb, 2'b11, cb, 6'h00});
    end
    // High voltage stays on only a few cycles, far below any row time limit
    ctl(4'h0);
  endtask : hv
  // ----------------------------------------
  // Clock, timeout and monitor
  // ----------------------------------------
  always #10 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      summarize();
    end
    if (!reset_i && (ref_o === 1'b1 || (hvo === 1'b1 && hv_q !== 1'b1))) begin
      if (vq.size() == 0) err_count++;
      else chk_ref(vq.pop_front(), ref_o);
    end
    if (!reset_i && pb !== pb_q) begin
      if (pq.size() == 0) err_count++;
      else chk(pq.pop_front(), {pb, sa});
    end
    if (!reset_i && cw_q === 1'b1) begin
      if (cq.size() == 0) err_count++;
      else chk({21'h0, cq.pop_front()}, {21'h0, pso, eo, mo});
    end
    cw_q <= cw;
    hv_q <= hvo;
    pb_q <= pb;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(66774));
    repeat (2) @(posedge core_clk_i);
    reset_i <= 1'b0;
    chk(24'hFFFFC0, {pb, sa});
    for (int i = 0; i < 13; i++) begin
      load(i < 8 ? 8'($urandom) : tbl[i-8]);
      repeat (4) begin
        // Half the targets sit just around the start address
        a = ($urandom % 2) ? 16'($urandom) : {2'b11, cb, 6'h00} - 16'h0002 + 16'($urandom % 4);
        if (a === PROTECT_BYTE_ADDR) a = a ^ 16'h0001;
        settv(1'($urandom));
        hv(modes[$urandom % 4], a, 8'($urandom));
      end
    end
    settv(1'b0);
    hv(3'b100, PROTECT_BYTE_ADDR, 8'h5A);
    settv(1'b1);
    hv(3'b100, PROTECT_BYTE_ADDR, 8'h5A);
    hv(3'b011, 16'h8000, 8'h00);
    repeat (4) @(posedge core_clk_i);
    summarize();
  end
endmodule : flash_block_protect_tb
`default_nettype wire
